/* iosd_decoder.sv */
// I/O space access decoder between core and peripheral registers
//
// Function
// - Bit set and clear reach every I/O register from 0x00 to 0x1F.
// - Bit test instructions get the selected bit of low-range registers.
// - Certain flags clear on a written one; written zero keeps them.
// - Bit set or clear changes only the addressed bit.
// - Bit set and clear act on I/O addresses 0x00 to 0x1F only.
// - IN and OUT use short addresses 0x00 to 0x3F, a 64-location field.
// - Data-space view of an I/O register is its short address plus 0x20.
// - Extended range 0x60 to 0xFF is reachable only by load and store.
// - Nonvolatile address bits above the top implemented bit are ignored.
`timescale 1ns/1ps
module iosd_decoder (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              req_valid,
  input  iosd_pkg::iosd_kind_t   req_kind,
  input  wire logic [15:0]       req_addr,
  input  wire logic [2:0]        req_bit,
  input  wire logic [7:0]        req_wdata,
  input  wire logic [7:0]        per_rdata,
  input  wire logic [7:0]        flag_evt,
  output logic      [7:0]        per_addr_q,
  output logic                   per_rd_q,
  output logic                   per_we_q,
  output logic      [7:0]        per_wmask_q,
  output logic      [7:0]        per_wdata_q,
  output logic      [7:0]        flag_status_q,
  output logic                   rsp_valid_q,
  output logic      [7:0]        rsp_rdata_q,
  output logic                   rsp_bit_q,
  output logic                   rsp_err_q
);
  import iosd_pkg::*;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic is_reserved(input logic [7:0] a);
    is_reserved = (a >= 8'h72 && a <= 8'h76) || (a == 8'h7D) ||
                  (a >= 8'h8C && a <= 8'hB5) || (a == 8'hB7) ||
                  (a >= 8'hBD && a <= 8'hC7) || (a >= 8'hD3);
  endfunction

  function automatic logic is_bit_op(input iosd_kind_t k);
    is_bit_op = (k == IOSD_SET_BIT) || (k == IOSD_CLR_BIT) ||
                (k == IOSD_SKIP_SET) || (k == IOSD_SKIP_CLR);
  endfunction

  // ---------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------
  logic       io_kind;
  logic       wr_kind;
  logic       claim;
  logic       range_err;
  logic [7:0] daddr;
  logic [7:0] bmask;
  logic [7:0] wmask;
  logic [7:0] wdata;

  always_comb begin
    io_kind   = (req_kind != IOSD_LOAD) && (req_kind != IOSD_STORE);
    wr_kind   = (req_kind == IOSD_OUT) || (req_kind == IOSD_STORE) ||
                (req_kind == IOSD_SET_BIT) || (req_kind == IOSD_CLR_BIT);
    bmask     = 8'h01 << req_bit;
    range_err = is_bit_op(req_kind) && (req_addr[5:0] > IOSD_BIT_IO_MAX);
    if (io_kind) begin
      // Six-bit field cannot reach the extended range
      daddr = {2'b00, req_addr[5:0]} + IOSD_IO_OFFSET;
      claim = 1'b1;
    end else begin
      daddr = req_addr[7:0];
      claim = (req_addr[15:8] == 8'h00) && (req_addr[7:0] >= IOSD_IO_OFFSET);
    end
    case (req_kind)
      IOSD_SET_BIT: begin
        wmask = bmask;
        wdata = bmask;
      end
      IOSD_CLR_BIT: begin
        wmask = bmask;
        wdata = 8'h00;
      end
      default: begin
        wmask = 8'hFF;
        wdata = req_wdata;
      end
    endcase
    if (daddr == IOSD_NVM_ADDR_HI) begin
      wmask = wmask & IOSD_NVM_HI_KEEP;
      wdata = wdata & IOSD_NVM_HI_KEEP;
    end
  end

  logic go;
  logic flag_hit;
  logic do_write;

  assign go       = req_valid && claim && !range_err;
  assign flag_hit = (daddr == IOSD_FLAG_ADDR);
  // Writes to reserved space are dropped rather than forwarded
  assign do_write = go && wr_kind && !is_reserved(daddr);

  // ---------------------------------------------------------------
  // Stage one: peripheral access
  // ---------------------------------------------------------------
  logic       s1_valid_q;
  logic       s1_rd_q;
  logic       s1_err_q;
  logic       s1_flag_q;
  logic [2:0] s1_bit_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      per_addr_q  <= 8'h00;
      per_rd_q    <= 1'b0;
      per_we_q    <= 1'b0;
      per_wmask_q <= 8'h00;
      per_wdata_q <= 8'h00;
    end else begin
      per_addr_q  <= daddr;
      per_rd_q    <= go && !wr_kind && !is_reserved(daddr) && !flag_hit;
      per_we_q    <= do_write && !flag_hit;
      per_wmask_q <= wmask;
      per_wdata_q <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_valid_q <= 1'b0;
      s1_rd_q    <= 1'b0;
      s1_err_q   <= 1'b0;
      s1_flag_q  <= 1'b0;
      s1_bit_q   <= 3'h0;
    end else begin
      s1_valid_q <= req_valid;
      s1_rd_q    <= go && !wr_kind && !is_reserved(daddr);
      s1_err_q   <= !claim || range_err;
      s1_flag_q  <= flag_hit;
      s1_bit_q   <= req_bit;
    end
  end

  // Status flags kept inside the decoder
  iosd_flag_reg u_flags (
    .clk     (clk),
    .reset   (reset),
    .evt     (flag_evt),
    .wr_en   (do_write && flag_hit),
    .wr_mask (wmask),
    .wr_data (wdata),
    .flags_q (flag_status_q)
  );

  // ---------------------------------------------------------------
  // Stage two: answer to the core
  // ---------------------------------------------------------------
  logic [7:0] rd_val;

  always_comb begin
    if (!s1_rd_q) begin
      rd_val = 8'h00;
    end else if (s1_flag_q) begin
      rd_val = flag_status_q;
    end else if (per_addr_q == IOSD_NVM_ADDR_HI) begin
      rd_val = per_rdata & IOSD_NVM_HI_KEEP;
    end else begin
      rd_val = per_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= 8'h00;
      rsp_bit_q   <= 1'b0;
      rsp_err_q   <= 1'b0;
    end else begin
      rsp_valid_q <= s1_valid_q;
      rsp_rdata_q <= rd_val;
      rsp_bit_q   <= rd_val[s1_bit_q];
      rsp_err_q   <= s1_valid_q && s1_err_q;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_low_bitop: assert property (@(posedge clk) disable iff (reset)
    req_valid && req_kind == IOSD_SET_BIT && req_addr[5:0] <= 6'h1F &&
    !is_reserved({2'b00, req_addr[5:0]} + 8'h20) &&
    ({2'b00, req_addr[5:0]} + 8'h20) != IOSD_FLAG_ADDR |=> per_we_q)
    else $error("bit set in low range not forwarded");

  chk_bit_test: assert property (@(posedge clk) disable iff (reset)
    s1_valid_q && s1_rd_q && !s1_flag_q &&
    per_addr_q != IOSD_NVM_ADDR_HI |=>
    rsp_bit_q == $past(per_rdata[s1_bit_q]))
    else $error("tested bit does not match register");

  chk_w1c_clear: assert property (@(posedge clk) disable iff (reset)
    do_write && flag_hit && (wmask & wdata & ~flag_evt) != 8'h00 |=>
    (flag_status_q & $past(wmask & wdata & ~flag_evt)) == 8'h00)
    else $error("written one did not clear flag");

  chk_single_bit: assert property (@(posedge clk) disable iff (reset)
    req_valid && (req_kind == IOSD_SET_BIT || req_kind == IOSD_CLR_BIT)
    |=> $onehot0(per_wmask_q))
    else $error("bit operation touches more than one bit");

  chk_bit_range: assert property (@(posedge clk) disable iff (reset)
    req_valid && is_bit_op(req_kind) && req_addr[5:0] > 6'h1F
    |=> !per_we_q ##1 rsp_err_q)
    else $error("bit operation above low range accepted");

  chk_io_offset: assert property (@(posedge clk) disable iff (reset)
    req_valid && req_kind == IOSD_IN |=>
    per_addr_q == $past(req_addr[5:0]) + 8'h20 && per_addr_q < 8'h60)
    else $error("short address mapped wrongly");

  chk_ext_store: assert property (@(posedge clk) disable iff (reset)
    req_valid && req_kind == IOSD_STORE && req_addr == 16'h0080
    |=> per_we_q && per_addr_q == 8'h80)
    else $error("extended register not reached by store");

  chk_nvm_mask: assert property (@(posedge clk) disable iff (reset)
    per_we_q && per_addr_q == IOSD_NVM_ADDR_HI |->
    (per_wdata_q & ~IOSD_NVM_HI_KEEP) == 8'h00)
    else $error("unimplemented address bits forwarded");

  chk_rsv_read: assert property (@(posedge clk) disable iff (reset)
    req_valid && req_kind == IOSD_LOAD && req_addr == 16'h00F0
    |=> !per_we_q && !per_rd_q ##1 rsp_rdata_q == 8'h00)
    else $error("reserved location not read as zero");

endmodule // iosd_decoder

/* iosd_pkg.sv */
// Constants and types shared by the I/O space access decoder
package iosd_pkg;

  typedef enum logic [2:0] {
    IOSD_IN,
    IOSD_OUT,
    IOSD_LOAD,
    IOSD_STORE,
    IOSD_SET_BIT,
    IOSD_CLR_BIT,
    IOSD_SKIP_SET,
    IOSD_SKIP_CLR
  } iosd_kind_t;

  localparam logic [5:0]  IOSD_BIT_IO_MAX   = 6'h1F;
  localparam logic [7:0]  IOSD_IO_OFFSET    = 8'h20;
  localparam logic [7:0]  IOSD_EXT_FIRST    = 8'h60;
  localparam logic [7:0]  IOSD_FLAG_ADDR    = 8'h3C;
  localparam logic [7:0]  IOSD_FLAG_RESET   = 8'h00;
  localparam logic [7:0]  IOSD_NVM_ADDR_HI  = 8'h42;
  localparam int          IOSD_NVM_TOP_BIT  = 8;
  localparam logic [7:0]  IOSD_NVM_HI_KEEP  =
    8'((1 << (IOSD_NVM_TOP_BIT - 7)) - 1);

endpackage

/* iosd_flag_reg.sv */
// Event flag byte with write-one-to-clear bits
`timescale 1ns/1ps
module iosd_flag_reg (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] evt,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_mask,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] flags_q
);
  import iosd_pkg::*;

  logic [7:0] clr;

  // Only masked bits written as one clear; a new event wins over a clear
  assign clr = wr_en ? (wr_mask & wr_data) : 8'h00;

  always_ff @(posedge clk) begin
    if (reset) begin
      flags_q <= IOSD_FLAG_RESET;
    end else begin
      flags_q <= (flags_q & ~clr) | evt;
    end
  end

endmodule // iosd_flag_reg

/* iosd_periph_model.sv */
// Peripheral register file answering the decoder's strobes
`timescale 1ns/1ps
module iosd_periph_model (
  input  wire logic       clk,
  input  wire logic [7:0] addr,
  input  wire logic       rd,
  input  wire logic       we,
  input  wire logic [7:0] wmask,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  initial foreach (mem[i]) mem[i] = 8'h00;
  // Masked write keeps the other bits, as a real register would
  always @(posedge clk) begin
    if (we) mem[addr] <= (mem[addr] & ~wmask) | (wdata & wmask);
    last <= rdata;
  end
  // Unselected bus toggles so stale data never passes for a read
  assign rdata = rd ? mem[addr] : ~last;
endmodule // iosd_periph_model

/* testbench.sv */
// Self-checking bench for the I/O space access decoder
`timescale 1ns/1ps
module testbench;
  import iosd_pkg::*;
  logic        clk = 0, reset = 1, req_valid = 0;
  iosd_kind_t  req_kind = IOSD_IN, rk;
  logic [15:0] req_addr = 16'h0000, ra;
  logic [2:0]  req_bit = 3'h0;
  logic [7:0]  req_wdata = 8'h00, flag_evt = 8'h00, per_rdata;
  logic [7:0]  per_addr_q, per_wmask_q, per_wdata_q, flag_status_q;
  logic [7:0]  rsp_rdata_q;
  logic        per_rd_q, per_we_q, rsp_valid_q, rsp_bit_q, rsp_err_q;
  int          bad_count = 0, compares = 0, seed = 96, fl = 0;
  int          mem [256];
  // ----------------------------------------------------------------
  // Clock and instances
  // ----------------------------------------------------------------
  always #50 clk = ~clk;
  iosd_decoder DUT (.clk(clk), .reset(reset), .req_valid(req_valid),
    .req_kind(req_kind), .req_addr(req_addr), .req_bit(req_bit),
    .req_wdata(req_wdata), .per_rdata(per_rdata), .flag_evt(flag_evt),
    .per_addr_q(per_addr_q), .per_rd_q(per_rd_q), .per_we_q(per_we_q),
    .per_wmask_q(per_wmask_q), .per_wdata_q(per_wdata_q),
    .flag_status_q(flag_status_q), .rsp_valid_q(rsp_valid_q),
    .rsp_rdata_q(rsp_rdata_q), .rsp_bit_q(rsp_bit_q),
    .rsp_err_q(rsp_err_q));
  iosd_periph_model PER (.clk(clk), .addr(per_addr_q), .rd(per_rd_q),
    .we(per_we_q), .wmask(per_wmask_q), .wdata(per_wdata_q),
    .rdata(per_rdata));
  // ----------------------------------------------------------------
  // Checking and reference model
  // ----------------------------------------------------------------
  task chk(input string n, input int e, input logic [7:0] g);
    compares++;
    if (g !== 8'(e)) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, 8'(e), g);
    end
  endtask
  task final_report;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic bit rsvd(int a);
    return (a >= 8'h72 && a <= 8'h76) || a == 8'h7D || a == 8'hB7 ||
      (a >= 8'h8C && a <= 8'hB5) || (a >= 8'hBD && a <= 8'hC7) ||
      a >= 8'hD3;
  endfunction
  task pulse(input logic [7:0] e);
    @(posedge clk) #1 flag_evt = e;
    @(posedge clk) #1 flag_evt = 8'h00;
    fl |= e;
    chk("flags", fl, flag_status_q);
  endtask
  task acc(input iosd_kind_t k, input logic [15:0] a,
           input logic [2:0] b, input logic [7:0] wd);
    int d, m, w, v;
    bit io, wr, err, fwd;
    io = !(k inside {IOSD_LOAD, IOSD_STORE});
    d = io ? int'(a[5:0]) + int'(IOSD_IO_OFFSET) : int'(a);
    wr = k inside {IOSD_OUT, IOSD_STORE, IOSD_SET_BIT, IOSD_CLR_BIT};
    err = k >= IOSD_SET_BIT ? a[5:0] > 6'h1F : d < 8'h20 || d > 8'hFF;
    m = k inside {IOSD_SET_BIT, IOSD_CLR_BIT} ? 1 << b : 8'hFF;
    w = k == IOSD_SET_BIT ? m : k == IOSD_CLR_BIT ? 0 : wd;
    fwd = !err && !rsvd(d) && d != 8'h3C;
    v = !fwd && d != 8'h3C ? 0 : d == 8'h3C ? fl : d == 8'h42 ?
      mem[d] & 1 : mem[d];
    @(posedge clk) #1 req_valid = 1;
    req_kind = k; req_addr = a; req_bit = b; req_wdata = wd;
    @(posedge clk) #1 req_valid = 0;
    chk("rsp_valid", 0, rsp_valid_q);
    chk("per_we", fwd && wr, per_we_q);
    chk("per_rd", fwd && !wr, per_rd_q);
    if (fwd) chk("per_addr", d, per_addr_q);
    if (fwd && wr && d != 8'h42) begin
      chk("per_wmask", m, per_wmask_q);
      chk("per_wdata", w & m, per_wdata_q & per_wmask_q);
    end
    @(posedge clk) #1;
    chk("rsp_valid", 1, rsp_valid_q);
    chk("rsp_err", err, rsp_err_q);
    if (k < IOSD_SKIP_SET) chk("rsp_rdata", wr ? 0 : v, rsp_rdata_q);
    if (k >= IOSD_SKIP_SET && !err) chk("rsp_bit", v[b], rsp_bit_q);
    if (!err && wr && d == 8'h3C) fl &= ~(w & m);
    else if (fwd && wr) mem[d] = (mem[d] & ~m) | (w & m);
    chk("flags", fl, flag_status_q);
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    foreach (mem[i]) mem[i] = 0;
    repeat (6) @(posedge clk);
    #1 reset = 0;
    for (int k = 0; k < 8; k++) begin
      pulse(8'hFF);
      acc(iosd_kind_t'(k), k == 2 || k == 3 ? 16'h003C : 16'h001C,
          3'(k), 8'h0F);
    end
    $display("test flag byte done");
    acc(IOSD_STORE, 16'h0042, 3'h0, 8'hFF);
    acc(IOSD_LOAD, 16'h0042, 3'h0, 8'h00);
    acc(IOSD_STORE, 16'h0042, 3'h0, 8'h00);
    acc(IOSD_STORE, 16'h0080, 3'h0, 8'h5A);
    acc(IOSD_LOAD, 16'h0080, 3'h0, 8'h00);
    acc(IOSD_LOAD, 16'h00F0, 3'h0, 8'h00);
    $display("test nvm high byte done");
    // Stores never aim at reserved places; reading them must give zero
    for (int i = 0; i < 600; i++) begin
      if ($random(seed) % 4 == 0) pulse(8'($random(seed)));
      rk = iosd_kind_t'(3'($random(seed)));
      ra = rk inside {IOSD_LOAD, IOSD_STORE} ?
        16'($unsigned($random(seed)) % 320) : 16'($random(seed));
      if (rk == IOSD_STORE && ra < 16'h0100 && rsvd(ra)) rk = IOSD_LOAD;
      acc(rk, ra, 3'($random(seed)), 8'($random(seed)));
    end
    $display("test random access done");
    final_report;
  end
  initial begin
    #2000000;
    bad_count++;
    $display("watchdog expired");
    final_report;
  end
endmodule // testbench
